/* sop_pkg.sv */
// constants and types for the security region and parameter space access block
package sop_pkg;
  localparam int          ADDR_W        = 24;
  localparam int          REGION_CNT    = 4;
  localparam int          REGION_BYTES  = 256;
  localparam int          BYTE_IDX_W    = 8;
  localparam int          REGION_IDX_W  = 2;
  localparam int          USER_IDX_W    = 10;
  localparam int          REGION_LSB    = 12;
  localparam int          HIGH_LSB      = 14;
  localparam int          GAP_LSB       = 8;
  localparam int          GAP_MSB       = 11;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [7:0]  CMD_PARAM_RD  = 8'h5A;
  // parameter space layout
  localparam logic [7:0]  HDR_SIG0      = 8'h53;
  localparam logic [7:0]  HDR_SIG1      = 8'h46;
  localparam logic [7:0]  HDR_SIG2      = 8'h44;
  localparam logic [7:0]  HDR_SIG3      = 8'h50;
  localparam logic [7:0]  HDR_MINOR     = 8'h06;
  localparam logic [7:0]  HDR_MAJOR     = 8'h01;
  localparam logic [7:0]  HDR_NUM_PARAM = 8'h03;
  localparam logic [7:0]  HDR_UNUSED    = 8'hFF;
  localparam logic [7:0]  OFS_TABLE     = 8'h80;
  localparam logic [7:0]  OFS_END       = 8'hBF;
  localparam logic [7:0]  OFS_RSVD      = 8'hC0;
  localparam logic [7:0]  OFS_UID       = 8'hF8;
  localparam logic [2:0]  UID_IDX_MASK  = 3'h7;
  localparam logic [REGION_IDX_W-1:0] REGION_PARAM = 2'h0;

  // commands handed over by the serial front end
  typedef enum logic [2:0] {
    SOP_OP_READ   = 3'h0,
    SOP_OP_PARAM  = 3'h1,
    SOP_OP_PROG   = 3'h2,
    SOP_OP_ERASE  = 3'h3,
    SOP_OP_LOCK   = 3'h4
  } sop_op_t;

  // gray codes along idle -> fetch -> store
  typedef enum logic [1:0] {
    SOP_IDLE  = 2'b00,
    SOP_FETCH = 2'b01,
    SOP_STORE = 2'b11,
    SOP_ERASE = 2'b10
  } sop_state_t;
endpackage

/* sop_mem_if.sv */
// carrier between the access controller and the user region store
`timescale 1ns/1ps
interface sop_mem_if #(parameter int AW = 10);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface

/* sop_user_mem.sv */
// byte store for the three user security regions, registered read data
`timescale 1ns/1ps
module sop_user_mem #(
  parameter int DEPTH = 768,
  parameter int AW    = 10
) (
  // clock
  input  wire logic sys_clk,
  // access port
  sop_mem_if.mem    port
);
  logic [7:0] store [DEPTH];
  logic [7:0] rdata_q;

  // write-through is not needed; reads see the old byte
  always_ff @(posedge sys_clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_q <= store[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule

/* sop_sec_ctrl.sv */
// access policy and address decode for the security regions and parameter space
`timescale 1ns/1ps
//
// Behaviour
// - Four security regions of 256 bytes each live apart from the main array.
// - A region whose one-time lock bit is set refuses all later changes, forever.
// - Region 0 holds the parameter data, also returned by the parameter read command.
// - Regions 1 to 3 are erased, programmed and locked independently of each other.
// - Region n answers at n*1000h through n*1000h+FFh; reads elsewhere return FFh, writes and locks elsewhere are refused.
// - Command code 5Ah reads the parameter space instead of the main array.
// - The parameter space is factory content and host writes to it have no effect.
// - Parameter byte 0 and 1 read as 53h and 46h, the header signature.
// - Header at 0, table at 80h, defined up to BFh, C0h-F7h reserved, F8h-FFh unique id.
// - The header carries the signature, a minor and major revision and the parameter header count.
// - All these commands carry a full 24-bit address.
module sop_sec_ctrl
  import sop_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter int          USER_CNT  = 3
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // stored lock bits, read back at reset
  input  wire logic [sop_pkg::REGION_CNT-1:0] nv_lock,
  // decoded command from the serial front end
  input  wire logic                      cmd_valid,
  input  wire sop_pkg::sop_op_t          cmd_op,
  input  wire logic [sop_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]                cmd_data,
  // answers
  output logic                           busy,
  output logic                           rd_valid,
  output logic [7:0]                     rd_data,
  output logic                           done,
  output logic                           refused,
  output logic [sop_pkg::REGION_CNT-1:0] lock_state
);
  import sop_pkg::*;

  // true when the address lies inside one of the four windows
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[ADDR_W-1:HIGH_LSB] == '0) && (a[GAP_MSB:GAP_LSB] == '0);
  endfunction

  function automatic logic [REGION_IDX_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    region_of = a[REGION_LSB+REGION_IDX_W-1:REGION_LSB];
  endfunction

  // factory content of region 0, laid out header first then table space
  function automatic logic [7:0] param_byte(input logic [BYTE_IDX_W-1:0] ofs);
    logic [2:0] k;
    k = ofs[2:0] & UID_IDX_MASK;
    if (ofs >= OFS_UID) begin
      param_byte = UNIQUE_ID[{k, 3'h0} +: 8];
    end else begin
      unique case (ofs)
        8'h00:   param_byte = HDR_SIG0;
        8'h01:   param_byte = HDR_SIG1;
        8'h02:   param_byte = HDR_SIG2;
        8'h03:   param_byte = HDR_SIG3;
        8'h04:   param_byte = HDR_MINOR;
        8'h05:   param_byte = HDR_MAJOR;
        8'h06:   param_byte = HDR_NUM_PARAM;
        8'h07:   param_byte = HDR_UNUSED;
        default: param_byte = ERASED_BYTE;
      endcase
    end
  endfunction

  sop_mem_if #(.AW(USER_IDX_W)) mport ();

  sop_user_mem #(
    .DEPTH (USER_CNT * REGION_BYTES),
    .AW    (USER_IDX_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .port    (mport)
  );

  // state
  sop_state_t                  state;
  sop_state_t                  next_state;
  sop_op_t                     op;
  sop_op_t                     next_op;
  logic [USER_IDX_W-1:0]       ptr;
  logic [USER_IDX_W-1:0]       next_ptr;
  logic [7:0]                  wbyte;
  logic [7:0]                  next_wbyte;
  logic [BYTE_IDX_W-1:0]       cnt;
  logic [BYTE_IDX_W-1:0]       next_cnt;
  logic                        is_param;
  logic                        next_is_param;
  logic                        oob;
  logic                        next_oob;
  logic [REGION_CNT-1:0]       lock = '0; // unprogrammed cells read unlocked at power-up
  logic [REGION_CNT-1:0]       next_lock;
  logic                        next_busy;
  logic                        next_rd_valid;
  logic [7:0]                  next_rd_data;
  logic                        next_done;
  logic                        next_refused;
  logic [REGION_IDX_W-1:0]     reg_sel;
  logic [USER_IDX_W-1:0]       user_base;
  logic                        wr_blocked;

  // user store index: region 1 maps to word 0
  always_comb begin
    reg_sel    = region_of(cmd_addr);
    user_base  = USER_IDX_W'((reg_sel - 2'h1) * REGION_BYTES);
    wr_blocked = !addr_ok(cmd_addr) || (reg_sel == REGION_PARAM) || lock[reg_sel];
  end

  // next-state and answer logic
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_ptr      = ptr;
    next_wbyte    = wbyte;
    next_cnt      = cnt;
    next_is_param = is_param;
    next_oob      = oob;
    next_lock     = lock;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    next_done     = 1'b0;
    next_refused  = 1'b0;
    mport.addr    = ptr;
    mport.we      = 1'b0;
    mport.wdata   = wbyte;
    unique case (state)
      SOP_IDLE: begin
        if (cmd_valid) begin
          next_op    = cmd_op;
          next_ptr   = user_base + USER_IDX_W'(cmd_addr[BYTE_IDX_W-1:0]);
          next_wbyte = cmd_data;
          mport.addr = next_ptr;
          unique case (cmd_op)
            SOP_OP_READ, SOP_OP_PARAM: begin
              // 5Ah always targets region 0 whatever the upper bits say
              next_is_param = (cmd_op == SOP_OP_PARAM) || (reg_sel == REGION_PARAM);
              next_oob      = (cmd_op == SOP_OP_READ) && !addr_ok(cmd_addr);
              next_cnt      = cmd_addr[BYTE_IDX_W-1:0];
              next_state    = SOP_FETCH;
            end
            SOP_OP_PROG: begin
              if (wr_blocked) begin
                next_refused = 1'b1;
              end else begin
                next_state = SOP_FETCH;
              end
            end
            SOP_OP_ERASE: begin
              if (wr_blocked) begin
                next_refused = 1'b1;
              end else begin
                next_ptr   = user_base;
                next_cnt   = '0;
                next_state = SOP_ERASE;
              end
            end
            SOP_OP_LOCK: begin
              if (!addr_ok(cmd_addr) || (reg_sel == REGION_PARAM)) begin
                next_refused = 1'b1;
              end else begin
                next_lock[reg_sel] = 1'b1;
                next_done          = 1'b1;
              end
            end
            default: next_refused = 1'b1;
          endcase
        end
      end
      SOP_FETCH: begin
        // one cycle for the store's registered read
        next_state = SOP_STORE;
      end
      SOP_STORE: begin
        next_state = SOP_IDLE;
        next_done  = 1'b1;
        if (op == SOP_OP_PROG) begin
          // programming only clears bits, like the array cells
          mport.we    = 1'b1;
          mport.wdata = mport.rdata & wbyte;
        end else begin
          next_rd_valid = 1'b1;
          if (oob) begin
            next_rd_data = ERASED_BYTE;
          end else if (is_param) begin
            next_rd_data = param_byte(cnt);
          end else begin
            next_rd_data = mport.rdata;
          end
        end
      end
      SOP_ERASE: begin
        mport.we    = 1'b1;
        mport.wdata = ERASED_BYTE;
        next_ptr    = ptr + USER_IDX_W'(1);
        next_cnt    = cnt + BYTE_IDX_W'(1);
        if (cnt == BYTE_IDX_W'(REGION_BYTES - 1)) begin
          next_state = SOP_IDLE;
          next_done  = 1'b1;
        end
      end
      default: next_state = SOP_IDLE;
    endcase
    next_busy = (next_state != SOP_IDLE);
  end

  // registers; lock bits survive reset by reloading and keeping what was set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= SOP_IDLE;
      op         <= SOP_OP_READ;
      ptr        <= '0;
      wbyte      <= '0;
      cnt        <= '0;
      is_param   <= 1'b0;
      oob        <= 1'b0;
      lock       <= lock | nv_lock;
      busy       <= 1'b0;
      rd_valid   <= 1'b0;
      rd_data    <= '0;
      done       <= 1'b0;
      refused    <= 1'b0;
      lock_state <= '0;
    end else begin
      state      <= next_state;
      op         <= next_op;
      ptr        <= next_ptr;
      wbyte      <= next_wbyte;
      cnt        <= next_cnt;
      is_param   <= next_is_param;
      oob        <= next_oob;
      lock       <= next_lock | lock;
      busy       <= next_busy;
      rd_valid   <= next_rd_valid;
      rd_data    <= next_rd_data;
      done       <= next_done;
      refused    <= next_refused;
      lock_state <= next_lock | lock;
    end
  end
endmodule

/* sop_host.sv */
// host model issuing single decoded commands to the security block
`timescale 1ns/1ps
module sop_host
  import sop_pkg::*;
(
  // clock
  input  wire logic                  sys_clk,
  // command side
  output logic                       cmd_valid,
  output sop_pkg::sop_op_t           cmd_op,
  output logic [sop_pkg::ADDR_W-1:0] cmd_addr,
  output logic [7:0]                 cmd_data,
  // answers
  input  wire logic                  done,
  input  wire logic                  refused,
  input  wire logic [7:0]            rd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = SOP_OP_READ;
    cmd_addr = 24'h000000;
    cmd_data = 8'h00;
  end

  // only called once the previous command ended, so busy is low at the taking edge
  task automatic issue(input sop_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic rf, output logic fn);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // released lines flip so stale values cannot pass for a hold
    cmd_addr = ~a;
    cmd_data = ~d;
    // lock and refusal answer at the taking edge, so look before waiting
    fn = done;
    rf = refused;
    for (n = 0; n < 300 && !fn && !rf; n++) begin
      @(negedge sys_clk);
      fn = done;
      rf = refused;
    end
    q = rd_data;
  endtask
endmodule

/* sop_sec_ctrl_props.sv */
// port assertions for the security region access block
`timescale 1ns/1ps
module sop_sec_ctrl_props
  import sop_pkg::*;
(
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      sys_rst,
  // inputs
  input wire logic [sop_pkg::REGION_CNT-1:0] nv_lock,
  input wire logic                      cmd_valid,
  input wire sop_pkg::sop_op_t          cmd_op,
  input wire logic [sop_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [7:0]                cmd_data,
  // outputs
  input wire logic                      busy,
  input wire logic                      rd_valid,
  input wire logic [7:0]                rd_data,
  input wire logic                      done,
  input wire logic                      refused,
  input wire logic [sop_pkg::REGION_CNT-1:0] lock_state
);
  // decode of the command seen at the taking edge
  wire logic       take = cmd_valid && !busy;
  wire logic [1:0] rgn = cmd_addr[13:12];
  wire logic       addr_ok = cmd_addr[23:14] == 10'h0 && cmd_addr[11:8] == 4'h0;
  wire logic       lkd = lock_state[rgn] || nv_lock[rgn];
  wire logic       wr_ok = addr_ok && rgn != 2'h0 && !lkd;
  wire logic       is_wr = cmd_op == SOP_OP_PROG || cmd_op == SOP_OP_ERASE;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_read_lat; take && (cmd_op == SOP_OP_READ || cmd_op == SOP_OP_PARAM)
    |=> busy[*2] ##1 (rd_valid && done && !busy); endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer mistimed");
  property p_param_sig; take && cmd_op == SOP_OP_PARAM && cmd_addr[7:1] == 7'h0
    |-> ##3 rd_data == ($past(cmd_addr[0], 3) ? HDR_SIG1 : HDR_SIG0); endproperty
  a_param_sig: assert property (p_param_sig) else $error("header signature wrong");
  property p_param_ro; take && is_wr && rgn == 2'h0 |=> refused && !done; endproperty
  a_param_ro: assert property (p_param_ro) else $error("write to region 0 taken");
  property p_locked; take && is_wr && addr_ok && lkd |=> refused && !busy; endproperty
  a_locked: assert property (p_locked) else $error("write to locked region taken");
  property p_prog_lat; take && cmd_op == SOP_OP_PROG && wr_ok
    |=> busy[*2] ##1 (done && !busy && !refused); endproperty
  a_prog_lat: assert property (p_prog_lat) else $error("program mistimed");
  property p_erase_len; take && cmd_op == SOP_OP_ERASE && wr_ok
    |=> busy[*8] ##249 (done && !busy); endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_lock_ok; take && cmd_op == SOP_OP_LOCK && addr_ok && rgn != 2'h0
    |=> done && lock_state[$past(rgn)]; endproperty
  a_lock_ok: assert property (p_lock_ok) else $error("lock not applied");
  property p_lock_sticky; (lock_state & $past(lock_state)) == $past(lock_state); endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

  // main scenarios reached
  c_erase: cover property (take && cmd_op == SOP_OP_ERASE && wr_ok);
  c_lock: cover property (take && cmd_op == SOP_OP_LOCK);
  c_refused: cover property (refused);
endmodule

bind sop_sec_ctrl sop_sec_ctrl_props sop_sec_ctrl_props_i (.sys_clk, .sys_rst, .nv_lock,
  .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .busy, .rd_valid, .rd_data, .done, .refused,
  .lock_state);

/* sop_sec_ctrl_test.sv */
// self-checking bench for the security region access block
`timescale 1ns/1ps
module sop_sec_ctrl_test;
  import sop_pkg::*;
  localparam logic [63:0] UID = 64'hA5C3_0F96_1E2D_4B78; // arbitrary value
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] nv_lock = 4'h8;
  logic cmd_valid, busy, rd_valid, done, refused, rf, fn;
  sop_op_t cmd_op;
  logic [23:0] cmd_addr;
  logic [7:0] cmd_data, rd_data, q, a, d;
  logic [3:0] lock_state;
  logic [7:0] shadow [0:3][0:255];
  int error_cnt = 0;
  int checks_done = 0;
  int i, r;

  sop_sec_ctrl #(.UNIQUE_ID(UID)) sop_sec_ctrl_i (.sys_clk, .sys_rst, .nv_lock, .cmd_valid,
    .cmd_op, .cmd_addr, .cmd_data, .busy, .rd_valid, .rd_data, .done, .refused, .lock_state);
  sop_host sop_host_i (.sys_clk, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .done, .refused,
    .rd_data);

  always #50 sys_clk = ~sys_clk;

  // expected parameter byte, header or unique id only
  function automatic logic [7:0] param_exp(input logic [7:0] x);
    logic [7:0] hdr [0:7];
    hdr = '{HDR_SIG0, HDR_SIG1, HDR_SIG2, HDR_SIG3, HDR_MINOR, HDR_MAJOR, HDR_NUM_PARAM,
            HDR_UNUSED};
    if (x < 8'h08) return hdr[x[2:0]];
    return 8'(UID >> {x[2:0], 3'h0});
  endfunction

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h0, got}, {7'h0, exp});
  endtask

  // one command, then refusal and completion checked against rx
  task automatic run(input sop_op_t op, input logic [23:0] ad, input logic [7:0] dt,
                     input logic rx);
    sop_host_i.issue(op, ad, dt, q, rf, fn);
    check1(rf, rx);
    check1(fn, !rx);
  endtask

  task automatic reset_and_check(input logic [3:0] nv, input logic [7:0] exp);
    @(negedge sys_clk);
    sys_rst = 1'b1;
    nv_lock = nv;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check8({4'h0, lock_state}, exp);
    $display("test reset done");
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // roughly 1200 cycles expected, cut off well beyond
  initial begin
    #(100 * 6000);
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(92));
    reset_and_check(4'h8, 8'h08);
    for (i = 0; i < 16; i++) begin
      a = 8'(i < 8 ? i : 240 + i);
      run(SOP_OP_PARAM, {16'h0, a}, 8'h00, 1'b0);
      check8(q, param_exp(a));
      run(SOP_OP_READ, {16'h0, a}, 8'h00, 1'b0);
      check8(q, param_exp(a));
    end
    run(SOP_OP_PROG, 24'h000000, 8'h00, 1'b1);
    run(SOP_OP_ERASE, 24'h000010, 8'h00, 1'b1);
    run(SOP_OP_LOCK, 24'h000000, 8'h00, 1'b1);
    run(SOP_OP_PARAM, 24'h000000, 8'h00, 1'b0);
    check8(q, HDR_SIG0);
    $display("test parameter space done");
    for (r = 1; r < 3; r++) begin
      run(SOP_OP_ERASE, {10'h0, r[1:0], 12'h000}, 8'h00, 1'b0);
      for (i = 0; i < 256; i++) shadow[r][i] = ERASED_BYTE;
    end
    run(SOP_OP_ERASE, 24'h003000, 8'h00, 1'b1);
    // random programs with reads of regions 1 and 2 at the same offset
    for (i = 0; i < 40; i++) begin
      r = 1 + $urandom_range(1);
      a = (i == 0) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      run(SOP_OP_PROG, {10'h0, r[1:0], 4'h0, a}, d, 1'b0);
      shadow[r][a] = shadow[r][a] & d;
      run(SOP_OP_READ, {10'h0, r[1:0], 4'h0, a}, 8'h00, 1'b0);
      check8(q, shadow[r][a]);
      run(SOP_OP_READ, {10'h0, 2'(3 - r), 4'h0, a}, 8'h00, 1'b0);
      check8(q, shadow[3 - r][a]);
    end
    run(SOP_OP_PROG, 24'h001100, 8'h00, 1'b1);
    run(SOP_OP_READ, 24'h001100, 8'h00, 1'b0);
    check8(q, ERASED_BYTE);
    $display("test user regions done");
    run(SOP_OP_LOCK, 24'h001000, 8'h00, 1'b0);
    check8({4'h0, lock_state}, 8'h0A);
    run(SOP_OP_PROG, 24'h0010FF, 8'h00, 1'b1);
    run(SOP_OP_ERASE, 24'h001000, 8'h00, 1'b1);
    run(SOP_OP_READ, 24'h0010FF, 8'h00, 1'b0);
    check8(q, shadow[1][255]);
    run(SOP_OP_PROG, 24'h0020FF, 8'h00, 1'b0);
    $display("test locking done");
    reset_and_check(4'h0, 8'h0A);
    test_done();
  end
endmodule
